/* logic/lpms_sequencer.sv */
// Purpose: standby and halt entry, wake qualification, pll lock and resume timing
// Assumes: system clock equals ref_clk while the pll runs
// Notes:   idle mode needs nothing from this block and is left to the core
`timescale 1ns/1ps
module lpms_sequencer #(
  parameter int PLL_LOCK_CYCLES = lpms_pkg::PLL_LOCK_CYC
) (
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic       idle_exec,
  input  wire logic       lpc_wr,
  input  wire logic [8:0] lpc_wdata,
  input  wire logic       flash_asleep,
  input  wire logic       wake_irq_en,
  input  wire logic       nonmaskable_wake_input_n,
  input  wire logic       reset_pin_input_n,
  input  wire logic       standby_wake_n,
  output logic            system_clock_en,
  output logic            core_clock_en,
  output logic            osc_enable,
  output logic            pll_enable,
  output logic            low_power_active,
  output logic            resume_exec,
  output logic            wake_irq
);
  localparam logic [17:0] PLL_LOAD = 18'(PLL_LOCK_CYCLES - 1);

  lpms_pkg::lpms_state_type state_ff, nxt_state;
  lpms_pkg::lpms_mode_type  mode_ff, nxt_mode;
  logic [5:0]  qual_ff, nxt_qual;
  logic        qen_ff, nxt_qen;
  logic [17:0] cnt_ff, nxt_cnt;
  logic [6:0]  qcnt_ff, nxt_qcnt;
  logic        sys_clk_ff, core_clk_ff, osc_ff, pll_ff, lp_ff, resume_ff, irq_ff;
  logic        nxt_sys_clk, nxt_core_clk, nxt_osc, nxt_pll, nxt_lp, nxt_resume, nxt_irq;
  logic        nmi_act, rst_act, wake_act;

  lpms_sync_if sync_bus ();
  assign sync_bus.pin_raw = {standby_wake_n, reset_pin_input_n, nonmaskable_wake_input_n};

  lpms_pin_sync u_sync (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .pins    (sync_bus.sync)
  );

  assign nmi_act  = !sync_bus.pin_level[lpms_pkg::PIN_NMI];
  assign rst_act  = !sync_bus.pin_level[lpms_pkg::PIN_RST];
  assign wake_act = !sync_bus.pin_level[lpms_pkg::PIN_WAKE];

  // control register: target mode and standby qualifier
  always_comb
  begin
    nxt_mode = mode_ff;
    nxt_qual = qual_ff;
    nxt_qen  = qen_ff;
    if (lpc_wr)
    begin
      nxt_mode = lpms_pkg::lpms_mode_type'(lpc_wdata[lpms_pkg::LPC_MODE_LSB +: 2]);
      nxt_qual = lpc_wdata[lpms_pkg::LPC_QUAL_LSB +: 6];
      nxt_qen  = lpc_wdata[lpms_pkg::LPC_QEN_BIT];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      mode_ff <= lpms_pkg::lpms_mode_type'(lpms_pkg::LPC_MODE_RST);
      qual_ff <= lpms_pkg::LPC_QUAL_RST;
      qen_ff  <= lpms_pkg::LPC_QEN_RST;
    end
    else
    begin
      mode_ff <= nxt_mode;
      qual_ff <= nxt_qual;
      qen_ff  <= nxt_qen;
    end
  end

  // sequencer; the mode is sampled at flush end, so a late write still counts
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt   = (cnt_ff != 18'h00000) ? cnt_ff - 18'h00001 : cnt_ff;
    nxt_qcnt  = 7'h00;
    unique case (state_ff)
      lpms_pkg::ST_RUN:
      begin
        if (idle_exec && (mode_ff == lpms_pkg::MODE_STANDBY || mode_ff == lpms_pkg::MODE_HALT))
        begin
          nxt_state = lpms_pkg::ST_FLUSH;
          nxt_cnt   = lpms_pkg::FLUSH_CYC - 18'h00001;
        end
      end
      lpms_pkg::ST_FLUSH:
      begin
        if (cnt_ff == 18'h00000)
          nxt_state = (mode_ff == lpms_pkg::MODE_HALT) ? lpms_pkg::ST_HALT
                                                         : lpms_pkg::ST_STANDBY;
      end
      lpms_pkg::ST_STANDBY:
      begin
        if (wake_act)
        begin
          nxt_qcnt = qcnt_ff + 7'h01;
          // qualified: accepted on the (2 + count)th active cycle
          if (!qen_ff || (qcnt_ff + 7'h01 >= lpms_pkg::QUAL_BASE + {1'h0, qual_ff}))
          begin
            nxt_state = lpms_pkg::ST_RESUME;
            nxt_cnt   = (flash_asleep ? lpms_pkg::FLASH_WAKE
                                      : lpms_pkg::STBY_OSC_CYC) - 18'h00001;
            nxt_qcnt  = 7'h00;
          end
        end
      end
      lpms_pkg::ST_HALT:
      begin
        if (nmi_act || rst_act)
          nxt_state = lpms_pkg::ST_OSC_ON;
      end
      lpms_pkg::ST_OSC_ON:
      begin
        if (!nmi_act && !rst_act)
        begin
          nxt_state = lpms_pkg::ST_PLL_LOCK;
          nxt_cnt   = PLL_LOAD;
        end
      end
      lpms_pkg::ST_PLL_LOCK:
      begin
        if (cnt_ff == 18'h00000)
        begin
          nxt_state = lpms_pkg::ST_RESUME;
          nxt_cnt   = (flash_asleep ? lpms_pkg::FLASH_WAKE
                                    : lpms_pkg::RAM_WAKE) - 18'h00001;
        end
      end
      lpms_pkg::ST_RESUME:
      begin
        if (cnt_ff == 18'h00000)
          nxt_state = lpms_pkg::ST_RUN;
      end
      default:
      begin
        nxt_state = lpms_pkg::ST_RUN;
      end
    endcase
    // outputs follow the next state so they line up with state_ff
    nxt_sys_clk  = (nxt_state == lpms_pkg::ST_RUN) || (nxt_state == lpms_pkg::ST_FLUSH)
                || (nxt_state == lpms_pkg::ST_RESUME);
    nxt_core_clk = nxt_sys_clk;
    nxt_osc      = (nxt_state != lpms_pkg::ST_HALT);
    nxt_pll      = (nxt_state != lpms_pkg::ST_HALT) && (nxt_state != lpms_pkg::ST_OSC_ON);
    nxt_lp       = !nxt_sys_clk;
    nxt_resume   = (state_ff == lpms_pkg::ST_RESUME) && (nxt_state == lpms_pkg::ST_RUN);
    nxt_irq      = nxt_resume && wake_irq_en;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      state_ff    <= lpms_pkg::ST_RUN;
      cnt_ff      <= 18'h00000;
      qcnt_ff     <= 7'h00;
      sys_clk_ff  <= 1'h1;
      core_clk_ff <= 1'h1;
      osc_ff      <= 1'h1;
      pll_ff      <= 1'h1;
      lp_ff       <= 1'h0;
      resume_ff   <= 1'h0;
      irq_ff      <= 1'h0;
    end
    else
    begin
      state_ff    <= nxt_state;
      cnt_ff      <= nxt_cnt;
      qcnt_ff     <= nxt_qcnt;
      sys_clk_ff  <= nxt_sys_clk;
      core_clk_ff <= nxt_core_clk;
      osc_ff      <= nxt_osc;
      pll_ff      <= nxt_pll;
      lp_ff       <= nxt_lp;
      resume_ff   <= nxt_resume;
      irq_ff      <= nxt_irq;
    end
  end

  assign system_clock_en  = sys_clk_ff;
  assign core_clock_en    = core_clk_ff;
  assign osc_enable       = osc_ff;
  assign pll_enable       = pll_ff;
  assign low_power_active = lp_ff;
  assign resume_exec      = resume_ff;
  assign wake_irq         = irq_ff;

  // helpers for checks only
  logic [17:0] stay_ff;
  logic        from_halt_ff;
  logic        flash_ff;
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      stay_ff      <= 18'h00000;
      from_halt_ff <= 1'h0;
      flash_ff     <= 1'h0;
    end
    else
    begin
      stay_ff      <= (nxt_state != state_ff) ? 18'h00000 : stay_ff + 18'h00001;
      from_halt_ff <= (nxt_state == lpms_pkg::ST_RESUME && state_ff != lpms_pkg::ST_RESUME)
                      ? (state_ff == lpms_pkg::ST_PLL_LOCK) : from_halt_ff;
      flash_ff     <= (nxt_state == lpms_pkg::ST_RESUME && state_ff != lpms_pkg::ST_RESUME)
                      ? flash_asleep : flash_ff;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  a_standby_entry: assert property ((state_ff == lpms_pkg::ST_RUN) && idle_exec
    && (mode_ff == lpms_pkg::MODE_STANDBY) |=> state_ff == lpms_pkg::ST_FLUSH ##32
    state_ff == lpms_pkg::ST_STANDBY) else $error("standby not entered");
  a_flush_clock_len: assert property ($rose(state_ff == lpms_pkg::ST_FLUSH) |->
    (system_clock_en ##31 (state_ff == lpms_pkg::ST_FLUSH && system_clock_en) ##1
    !system_clock_en)) else $error("flush length wrong");
  a_halt_after_flush: assert property ($fell(state_ff == lpms_pkg::ST_FLUSH)
    && mode_ff == lpms_pkg::MODE_HALT |-> state_ff == lpms_pkg::ST_HALT && !osc_enable
    && !core_clock_en) else $error("halt entry wrong");
  a_halt_all_off: assert property (state_ff == lpms_pkg::ST_HALT |-> !osc_enable
    && !pll_enable && !system_clock_en && !core_clock_en)
    else $error("clock on in halt");
  a_nmi_osc_only: assert property (state_ff == lpms_pkg::ST_HALT && nmi_act |=>
    osc_enable && !pll_enable && !core_clock_en) else $error("nmi wake wrong");
  a_pll_lock_len: assert property (state_ff == lpms_pkg::ST_PLL_LOCK
    && nxt_state != lpms_pkg::ST_PLL_LOCK |-> stay_ff == PLL_LOAD && !core_clock_en)
    else $error("pll lock length wrong");
  a_wake_irq: assert property ($fell(state_ff == lpms_pkg::ST_RESUME) |-> resume_exec
    && (wake_irq == $past(wake_irq_en)) ##1 !resume_exec) else $error("irq wrong");
  a_qual_time: assert property ($fell(state_ff == lpms_pkg::ST_STANDBY) && $past(qen_ff)
    |-> $past(qcnt_ff) == {1'h0, $past(qual_ff)} + 7'h01) else $error("qual wrong");
  a_standby_latency: assert property (state_ff == lpms_pkg::ST_RESUME && !from_halt_ff
    && nxt_state == lpms_pkg::ST_RUN |-> stay_ff == (flash_ff ? lpms_pkg::FLASH_WAKE
    : lpms_pkg::STBY_OSC_CYC) - 18'h00001) else $error("standby latency wrong");
  a_halt_latency: assert property (state_ff == lpms_pkg::ST_RESUME && from_halt_ff
    && nxt_state == lpms_pkg::ST_RUN |-> stay_ff == (flash_ff ? lpms_pkg::FLASH_WAKE
    : lpms_pkg::RAM_WAKE) - 18'h00001) else $error("halt latency wrong");
  a_idle_mode_stays: assert property (state_ff == lpms_pkg::ST_RUN && idle_exec
    && mode_ff == lpms_pkg::MODE_IDLE |=> state_ff == lpms_pkg::ST_RUN)
    else $error("idle mode moved");

  c_standby_trip: cover property (state_ff == lpms_pkg::ST_STANDBY ##1
    state_ff == lpms_pkg::ST_RESUME);
  c_halt_nmi: cover property (state_ff == lpms_pkg::ST_OSC_ON ##1
    state_ff == lpms_pkg::ST_PLL_LOCK);
  c_irq_out: cover property (wake_irq);
endmodule : lpms_sequencer

/* logic/lpms_pkg.sv */
// Purpose: constants and types for the low-power mode sequencer
// Assumes: one clock, ref_clk, stands for both the oscillator input clock and system clock
// Notes:   all counts are in ref_clk cycles
package lpms_pkg;
  typedef enum logic [2:0] {
    ST_RUN      = 3'h0,
    ST_FLUSH    = 3'h1,
    ST_STANDBY  = 3'h2,
    ST_HALT     = 3'h3,
    ST_OSC_ON   = 3'h4,
    ST_PLL_LOCK = 3'h5,
    ST_RESUME   = 3'h6
  } lpms_state_type;

  typedef enum logic [1:0] {
    MODE_IDLE    = 2'h0,
    MODE_STANDBY = 2'h1,
    MODE_HALT    = 2'h2
  } lpms_mode_type;

  localparam int          CNT_W         = 18;
  localparam int          PIN_CNT       = 3;
  localparam int          PIN_NMI       = 0;
  localparam int          PIN_RST       = 1;
  localparam int          PIN_WAKE      = 2;
  localparam int          LPC_MODE_LSB  = 0;
  localparam int          LPC_QUAL_LSB  = 2;
  localparam int          LPC_QEN_BIT   = 8;
  localparam logic [1:0]  LPC_MODE_RST  = 2'h0;
  localparam logic [5:0]  LPC_QUAL_RST  = 6'h00;
  localparam logic        LPC_QEN_RST   = 1'h0;
  localparam logic [17:0] FLUSH_CYC     = 18'h00020;
  localparam logic [17:0] STBY_OSC_CYC  = 18'h0000C;
  localparam logic [17:0] FLASH_WAKE    = 18'h00465;
  localparam logic [17:0] RAM_WAKE      = 18'h00023;
  localparam int          PLL_LOCK_CYC  = 131072;
  localparam logic [6:0]  QUAL_BASE     = 7'h02;
endpackage : lpms_pkg

/* logic/lpms_sync_if.sv */
// Purpose: carries raw wake pins into the synchroniser and clean levels back
// Assumes: pins are active low at the raw side
// Notes:   none
`timescale 1ns/1ps
interface lpms_sync_if;
  logic [2:0] pin_raw;
  logic [2:0] pin_level;
  modport sync (input pin_raw, output pin_level);
  modport user (output pin_raw, input pin_level);
endinterface : lpms_sync_if

/* logic/lpms_pin_sync.sv */
// Purpose: three-stage synchroniser with agreement filter for each wake pin
// Assumes: level resets high, the inactive level of active-low pins
// Notes:   a change shows 4 edges after it reaches the pin, the filter flop adds one
`timescale 1ns/1ps
module lpms_pin_sync (
  input wire logic   ref_clk,
  input wire logic   resetn,
  lpms_sync_if.sync  pins
);
  logic [2:0] s1_ff;
  logic [2:0] s2_ff;
  logic [2:0] s3_ff;
  logic [2:0] level_ff;
  logic [2:0] nxt_level;

  genvar gi;
  generate
    for (gi = 0; gi < lpms_pkg::PIN_CNT; gi++)
    begin : g_pin
      // only the second stage looks at the first, to keep metastability contained
      always_comb
      begin
        nxt_level[gi] = (s2_ff[gi] == s3_ff[gi]) ? s3_ff[gi] : level_ff[gi];
      end
      always_ff @(posedge ref_clk)
      begin
        if (!resetn)
        begin
          s1_ff[gi]    <= 1'h1;
          s2_ff[gi]    <= 1'h1;
          s3_ff[gi]    <= 1'h1;
          level_ff[gi] <= 1'h1;
        end
        else
        begin
          s1_ff[gi]    <= pins.pin_raw[gi];
          s2_ff[gi]    <= s1_ff[gi];
          s3_ff[gi]    <= s2_ff[gi];
          level_ff[gi] <= nxt_level[gi];
        end
      end
    end
  endgenerate

  assign pins.pin_level = level_ff;
endmodule : lpms_pin_sync

/* sim/lpms_wake_model.sv */
// Purpose: model of the outside wake sources driving the three active-low pins
// Assumes: pins are pulled up, so a released pin reads inactive high
// Notes:   pin index follows the package pin constants
`timescale 1ns/1ps
module lpms_wake_model (
  input  wire logic  ref_clk,
  output logic [2:0] pins_n
);
  initial pins_n = 3'h7;

  task automatic drive(input int i);
    @(posedge ref_clk);
    pins_n[i] <= 1'b0;
  endtask : drive

  // minimum hold enforced here: 8 edges for reset, 2 for nmi, 1 for wake, so a scenario can still drive a too-short wake pulse
  task automatic release_pin(input int i, input int n);
    int m;
    m = (i == lpms_pkg::PIN_RST) ? 8 : ((i == lpms_pkg::PIN_NMI) ? 2 : 1);
    repeat ((n < m) ? m : n) @(posedge ref_clk);
    pins_n[i] <= 1'b1;
  endtask : release_pin
endmodule : lpms_wake_model

/* sim/tb_top.sv */
// Purpose: self-checking bench for standby and halt entry and wake timing
// Assumes: pll lock shortened to 64 cycles, counts in ref_clk edges
// Notes:   each wait is bounded; a timeout ends the run as a failure
`timescale 1ns/1ps
module tb_top;
  localparam int PLL_SIM = 64;
  localparam int S_SYS   = 0;
  localparam int S_CORE  = 1;
  localparam int S_OSC   = 2;
  localparam int S_PLL   = 3;
  localparam int S_RES   = 5;
  logic       ref_clk;
  logic       resetn;
  logic       idle_exec;
  logic       lpc_wr;
  logic [8:0] lpc_wdata;
  logic       flash_asleep;
  logic       wake_irq_en;
  logic [2:0] pins_n;
  logic       system_clock_en;
  logic       core_clock_en;
  logic       osc_enable;
  logic       pll_enable;
  logic       low_power_active;
  logic       resume_exec;
  logic       wake_irq;
  logic [6:0] obs;
  int         err_total;
  int         checks;

  assign obs = {wake_irq, resume_exec, low_power_active, pll_enable, osc_enable,
                core_clock_en, system_clock_en};

  lpms_sequencer #(.PLL_LOCK_CYCLES(PLL_SIM)) lpms_sequencer_inst (
    .ref_clk                  (ref_clk),
    .resetn                   (resetn),
    .idle_exec                (idle_exec),
    .lpc_wr                   (lpc_wr),
    .lpc_wdata                (lpc_wdata),
    .flash_asleep             (flash_asleep),
    .wake_irq_en              (wake_irq_en),
    .nonmaskable_wake_input_n (pins_n[lpms_pkg::PIN_NMI]),
    .reset_pin_input_n        (pins_n[lpms_pkg::PIN_RST]),
    .standby_wake_n           (pins_n[lpms_pkg::PIN_WAKE]),
    .system_clock_en          (system_clock_en),
    .core_clock_en            (core_clock_en),
    .osc_enable               (osc_enable),
    .pll_enable               (pll_enable),
    .low_power_active         (low_power_active),
    .resume_exec              (resume_exec),
    .wake_irq                 (wake_irq)
  );

  lpms_wake_model lpms_wake_model_inst (
    .ref_clk (ref_clk),
    .pins_n  (pins_n)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic summarize();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize

  task automatic chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk_bit

  task automatic chk_cnt(input int got, input int exp);
    checks++;
    if (got != exp)
    begin
      err_total++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk_cnt

  // edges until an output reaches a level, compared to the expected count
  task automatic meas(input int sel, input logic val, input int exp);
    int n;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (obs[sel] !== val && n < 2000);
    if (obs[sel] !== val)
    begin
      err_total++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, obs[sel], val);
      summarize();
    end
    else
      chk_cnt(n, exp);
  endtask : meas

  task automatic wr_lpc(input logic [1:0] md, input logic [5:0] q, input logic qen,
                        input logic fl, input logic ie);
    @(posedge ref_clk);
    lpc_wr       <= 1'b1;
    lpc_wdata    <= {qen, q, md};
    flash_asleep <= fl;
    wake_irq_en  <= ie;
    @(posedge ref_clk);
    lpc_wr <= 1'b0;
    @(posedge ref_clk);
    idle_exec <= 1'b1;
    @(posedge ref_clk);
    idle_exec <= 1'b0;
  endtask : wr_lpc

  task automatic t_idle_modes();
    for (int k = 0; k < 2; k++)
    begin
      wr_lpc((k == 0) ? 2'h0 : 2'h3, 6'h00, 1'b0, 1'b0, 1'b0);
      repeat (40)
      begin
        @(posedge ref_clk);
        #1;
        chk_bit(system_clock_en, 1'b1);
      end
    end
  endtask : t_idle_modes

  task automatic t_standby(input logic [5:0] q, input logic qen, input logic fl,
                           input logic ie, input logic glitch);
    int e;
    wr_lpc(2'h1, q, qen, fl, ie);
    meas(S_SYS, 1'b0, 32);
    chk_bit(low_power_active, 1'b1);
    chk_bit(core_clock_en, 1'b0);
    if (glitch)
    begin
      lpms_wake_model_inst.drive(lpms_pkg::PIN_WAKE);
      lpms_wake_model_inst.release_pin(lpms_pkg::PIN_WAKE, int'(q) + 1);
      repeat (20)
      begin
        @(posedge ref_clk);
        #1;
        chk_bit(system_clock_en, 1'b0);
      end
    end
    // pin to level takes 4 edges, the sequencer acts one edge later
    e = qen ? 6 + int'(q) : 5;
    lpms_wake_model_inst.drive(lpms_pkg::PIN_WAKE);
    meas(S_SYS, 1'b1, e);
    chk_bit(low_power_active, 1'b0);
    fork
      lpms_wake_model_inst.release_pin(lpms_pkg::PIN_WAKE, 1);
    join_none
    meas(S_RES, 1'b1, fl ? 1125 : 12);
    chk_bit(wake_irq, ie);
  endtask : t_standby

  task automatic t_halt(input int pin, input logic fl, input logic ie);
    wr_lpc(2'h2, 6'h00, 1'b0, fl, ie);
    meas(S_SYS, 1'b0, 32);
    chk_bit(osc_enable, 1'b0);
    repeat (8)
    begin
      @(posedge ref_clk);
      #1;
      chk_bit(osc_enable | pll_enable | core_clock_en | system_clock_en, 1'b0);
    end
    lpms_wake_model_inst.drive(pin);
    meas(S_OSC, 1'b1, 5);
    repeat (6)
    begin
      @(posedge ref_clk);
      #1;
      chk_bit(pll_enable, 1'b0);
    end
    lpms_wake_model_inst.release_pin(pin, 1);
    meas(S_PLL, 1'b1, 5);
    chk_bit(core_clock_en, 1'b0);
    meas(S_CORE, 1'b1, PLL_SIM);
    chk_bit(low_power_active, 1'b0);
    meas(S_RES, 1'b1, fl ? 1125 : 35);
    chk_bit(wake_irq, ie);
    @(posedge ref_clk);
    #1;
    chk_bit(resume_exec, 1'b0);
  endtask : t_halt

  initial
  begin
    err_total    = 0;
    checks       = 0;
    resetn       = 1'b0;
    idle_exec    = 1'b0;
    lpc_wr       = 1'b0;
    lpc_wdata    = 9'h000;
    flash_asleep = 1'b0;
    wake_irq_en  = 1'b0;
    repeat (12) @(posedge ref_clk);
    resetn <= 1'b1;
    t_idle_modes();
    t_standby(6'h00, 1'b0, 1'b0, 1'b1, 1'b0);
    t_standby(6'h03, 1'b1, 1'b1, 1'b0, 1'b1);
    t_standby(6'h3F, 1'b1, 1'b0, 1'b1, 1'b0);
    t_halt(lpms_pkg::PIN_NMI, 1'b0, 1'b1);
    t_halt(lpms_pkg::PIN_RST, 1'b1, 1'b0);
    summarize();
  end
endmodule : tb_top
